/* File: design/ucr_pkg.sv */
/*
 Constants for the serial configuration-register command block: framing
 bytes, register addresses, defaults and timing figures.
 Assumes a 125 MHz system clock shared by both ends.
*/
package ucr_pkg;
    localparam int CLK_HZ = 125000000;
    localparam logic [7:0] HDR_BYTE = 8'hFF;
    localparam logic [7:0] SIZE_BYTE = 8'h02;
    localparam logic [7:0] ESC_BYTE = 8'hFE;
    localparam logic [7:0] ACK_BYTE = 8'h06;
    localparam logic [7:0] NAK_BYTE = 8'h15;
    // Volatile and non-volatile addresses
    localparam logic [7:0] A_RATE_V = 8'h4E;
    localparam logic [7:0] A_RATE_N = 8'h03;
    localparam logic [7:0] A_ADDR_V = 8'h4F;
    localparam logic [7:0] A_ADDR_N = 8'h04;
    localparam logic [7:0] A_WAIT_V = 8'h50;
    localparam logic [7:0] A_WAIT_N = 8'h05;
    localparam logic [7:0] A_RTRY_V = 8'h52;
    localparam logic [7:0] A_RTRY_N = 8'h07;
    localparam logic [7:0] A_CRC_V = 8'h53;
    localparam logic [7:0] A_CRC_N = 8'h08;
    localparam int NREG = 5;
    localparam logic [2:0] IDX_RATE = 3'h0;
    localparam logic [2:0] IDX_ADDR = 3'h1;
    localparam logic [2:0] IDX_WAIT = 3'h2;
    localparam logic [2:0] IDX_RTRY = 3'h3;
    localparam logic [2:0] IDX_CRC = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    // Factory defaults
    localparam logic [7:0] RATE_DEF = 8'h01;
    localparam logic [7:0] ADDR_DEF = 8'h00;
    localparam logic [7:0] WAIT_DEF = 8'h00;
    localparam logic [7:0] RTRY_DEF = 8'h03;
    localparam logic [7:0] CRC_ON = 8'h01;
    localparam logic [7:0] CRC_OFF = 8'h00;
    localparam logic [7:0] RATE_MIN = 8'h01;
    localparam logic [7:0] RATE_MAX = 8'h07;
    localparam logic [7:0] RATE_SLOW_MAX = 8'h02;
    localparam int AIR_SLOW_BPS = 19200;
    localparam int AIR_FAST_BPS = 153600;
    localparam int ACK_TO_SLOW_MS = 50;
    localparam int ACK_TO_FAST_MS = 30;
    localparam int ACK_TO_SLOW_CYC = ACK_TO_SLOW_MS * (CLK_HZ / 1000);
    localparam int ACK_TO_FAST_CYC = ACK_TO_FAST_MS * (CLK_HZ / 1000);
    localparam int BIT_W = 24;

    typedef logic [7:0] ucr_byte_t;

    // Serial bit period in clocks for a rate code (9600 on unknown)
    function automatic logic [23:0] ucr_bit_cycles(input logic [7:0] code);
        int bps;
        unique case (code)
            8'h02: bps = 19200;
            8'h03: bps = 38400;
            8'h04: bps = 57600;
            8'h05: bps = 115200;
            8'h06: bps = 10400;
            8'h07: bps = 31250;
            default: bps = 9600;
        endcase
        return 24'(CLK_HZ / bps);
    endfunction
endpackage

/* File: design/ucr_link_if.sv */
/*
 Serial link between the host end and the device end: one wire each way.
 Assumes both ends run on the same sys_clk; the ends still synchronise.
*/
`timescale 1ns/1ps
interface ucr_link_if;
    logic host_to_dev;
    logic dev_to_host;
    modport dev (input host_to_dev, output dev_to_host);
    modport host (output host_to_dev, input dev_to_host);
endinterface

/* File: design/ucr_uart.sv */
/*
 Byte serialiser and deserialiser, 8N1, with a run-time bit period.
 Assumes rx_pin is asynchronous; it passes two flops before use.
*/
`timescale 1ns/1ps
module ucr_uart (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [23:0] bit_cycles,
    // Transmit
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_pin,
    // Receive
    input wire logic rx_pin,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    typedef struct packed {
        logic [1:0] sync;
        logic tx_busy;
        logic [3:0] tx_bit;
        logic [9:0] tx_shift;
        logic [23:0] tx_cnt;
        logic rx_busy;
        logic [3:0] rx_bit;
        logic [7:0] rx_shift;
        logic [23:0] rx_cnt;
        logic rx_valid;
        logic [7:0] rx_data;
    } ucr_uart_st_t;

    ucr_uart_st_t st_reg, st_next;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    localparam logic [3:0] DATA_BITS = 4'h8;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[0], rx_pin};
        st_next.rx_valid = 1'b0;
        if (st_reg.tx_busy) begin
            if (st_reg.tx_cnt == 24'h0) begin
                st_next.tx_cnt = bit_cycles - 24'h1;
                st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
                if (st_reg.tx_bit == FRAME_BITS) begin
                    st_next.tx_busy = 1'b0;
                end else begin
                    st_next.tx_bit = st_reg.tx_bit + 4'h1;
                end
            end else begin
                st_next.tx_cnt = st_reg.tx_cnt - 24'h1;
            end
        end else if (tx_valid) begin
            st_next.tx_busy = 1'b1;
            st_next.tx_bit = 4'h0;
            st_next.tx_shift = {1'b1, tx_data, 1'b0};
            st_next.tx_cnt = bit_cycles - 24'h1;
        end
        // Sample mid-bit: start detection waits half a period
        if (!st_reg.rx_busy) begin
            if (!st_reg.sync[1]) begin
                st_next.rx_busy = 1'b1;
                st_next.rx_bit = 4'h0;
                st_next.rx_cnt = {1'b0, bit_cycles[23:1]};
            end
        end else if (st_reg.rx_cnt != 24'h0) begin
            st_next.rx_cnt = st_reg.rx_cnt - 24'h1;
        end else begin
            st_next.rx_cnt = bit_cycles - 24'h1;
            st_next.rx_bit = st_reg.rx_bit + 4'h1;
            if (st_reg.rx_bit == 4'h0 && st_reg.sync[1]) begin
                st_next.rx_busy = 1'b0;
            end else if (st_reg.rx_bit == FRAME_BITS) begin
                st_next.rx_busy = 1'b0;
            end
            if (st_reg.rx_bit != 4'h0 && st_reg.rx_bit <= DATA_BITS) begin
                st_next.rx_shift = {st_reg.sync[1], st_reg.rx_shift[7:1]};
            end
            if (st_reg.rx_bit == FRAME_BITS) begin
                st_next.rx_valid = st_reg.sync[1];
                st_next.rx_data = st_reg.rx_shift;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{sync: 2'h3, tx_shift: 10'h3FF, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_ready = !st_reg.tx_busy;
    assign tx_pin = st_reg.tx_busy ? st_reg.tx_shift[0] : 1'b1;
    assign rx_valid = st_reg.rx_valid;
    assign rx_data = st_reg.rx_data;
endmodule

/* File: design/ucr_device.sv */
/*
 Device end: interprets framed read/write commands over the serial link,
 keeps volatile and non-volatile setting copies, runs the retry timer and
 the receive-check gate.
 Assumes the radio side presents transmit outcomes and received packets
 as single-cycle events on plain ports.
*/
// Contract
// [RULE1] Read: header, size, escape, address; answer ack+value; code answers ack, address, value
// [RULE2] Write: header, size two, address, value
// [RULE3] Each setting has volatile and non-volatile address
// [RULE4] Rate codes 1..7 pick serial bit rate
// [RULE5] Air rate 19200 for codes 1-2, else 153600
// [RULE6] Non-volatile rate write waits for reset
// [RULE7] Volatile rate switches after acknowledge is sent
// [RULE8] Rate defaults to code 1
// [RULE9] Retransmit up to retry-count times
// [RULE10] Raise no-ack exception after last retry
// [RULE11] Ack timeout 50 ms slow, 30 ms fast
// [RULE12] Total time is (retries+1) times attempt time
// [RULE13] Enabled check drops failed unencrypted packets
// [RULE14] Check enable: 1 on, 0 off, default on
// [RULE15] Disabled check passes corrupt payload, not header
// [RULE16] Host leaves addressing kind alone
// [RULE17] Transmit wait limit stored, no effect
// [RULE18] Copy non-volatile into volatile before serving
`timescale 1ns/1ps
module ucr_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    ucr_link_if.dev link,
    // Radio transmit side
    input wire logic pkt_send,
    input wire logic pkt_sent,
    input wire logic radio_ack,
    output logic pkt_attempt,
    output logic no_radio_ack_exception,
    output logic tx_active,
    // Radio receive side
    input wire logic rx_pkt,
    input wire logic rx_encrypted,
    input wire logic rx_crc_ok,
    input wire logic rx_hdr_ok,
    output logic rx_deliver,
    // Status
    output logic [17:0] air_rate_bps,
    output logic [7:0] serial_rate_select,
    output logic ready
);
    localparam int NR = ucr_pkg::NREG;

    typedef enum logic [2:0] {
        S_BOOT = 3'b000, S_HDR = 3'b001, S_SIZE = 3'b010, S_ADR = 3'b011,
        S_RADR = 3'b100, S_VAL = 3'b101, S_RESP = 3'b110
    } ucr_cmd_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00, T_SEND = 2'b01, T_WAIT = 2'b10
    } ucr_tx_t;

    typedef struct packed {
        ucr_cmd_t cmd;
        logic [2:0] boot_idx;
        logic [NR*8-1:0] vol;
        logic [7:0] addr;
        logic [1:0] resp_cnt;
        logic [7:0] resp_val;
        logic [7:0] run_rate;
        logic [7:0] pend_rate;
        logic pend_sw;
        ucr_tx_t tx;
        logic [7:0] tries;
        logic [23:0] to_cnt;
        logic exc;
        logic attempt;
        logic deliver;
    } ucr_dev_st_t;

    ucr_dev_st_t st_reg, st_next;
    // Non-volatile store survives rst_n; only power-up loads defaults
    logic [NR*8-1:0] nvm_reg = {ucr_pkg::CRC_ON, ucr_pkg::RTRY_DEF,
        ucr_pkg::WAIT_DEF, ucr_pkg::ADDR_DEF,
        ucr_pkg::RATE_DEF}; // [RULE14] [RULE8]
    logic [NR*8-1:0] nvm_next;
    logic u_tx_valid, u_tx_ready, u_rx_valid;
    logic [7:0] u_tx_data, u_rx_data;
    logic [2:0] a_idx;
    logic a_nvm;

    // Map an address onto setting index and copy
    function automatic logic [3:0] ucr_decode(input logic [7:0] a);
        unique case (a)
            ucr_pkg::A_RATE_V: return {1'b0, ucr_pkg::IDX_RATE};
            ucr_pkg::A_RATE_N: return {1'b1, ucr_pkg::IDX_RATE};
            ucr_pkg::A_ADDR_V: return {1'b0, ucr_pkg::IDX_ADDR};
            ucr_pkg::A_ADDR_N: return {1'b1, ucr_pkg::IDX_ADDR};
            ucr_pkg::A_WAIT_V: return {1'b0, ucr_pkg::IDX_WAIT};
            ucr_pkg::A_WAIT_N: return {1'b1, ucr_pkg::IDX_WAIT};
            ucr_pkg::A_RTRY_V: return {1'b0, ucr_pkg::IDX_RTRY};
            ucr_pkg::A_RTRY_N: return {1'b1, ucr_pkg::IDX_RTRY};
            ucr_pkg::A_CRC_V: return {1'b0, ucr_pkg::IDX_CRC};
            ucr_pkg::A_CRC_N: return {1'b1, ucr_pkg::IDX_CRC};
            default: return {1'b0, ucr_pkg::IDX_NONE};
        endcase
    endfunction

    function automatic logic [7:0] ucr_field(input logic [NR*8-1:0] v,
                                             input logic [2:0] i);
        return v[i*8 +: 8];
    endfunction

    assign {a_nvm, a_idx} = ucr_decode(st_reg.addr); // [RULE3]

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic slow;
        logic [3:0] d;
        slow = 1'b0;
        d = 4'h0;
        st_next = st_reg;
        nvm_next = nvm_reg;
        st_next.attempt = 1'b0;
        st_next.exc = 1'b0;
        st_next.deliver = 1'b0;
        u_tx_valid = 1'b0;
        u_tx_data = ucr_pkg::ACK_BYTE;
        unique case (st_reg.cmd)
            S_BOOT: begin
                // Volatile copies load from non-volatile before serving
                st_next.vol[st_reg.boot_idx*8 +: 8] =
                    ucr_field(nvm_reg, st_reg.boot_idx); // [RULE18]
                if (st_reg.boot_idx == 3'(NR - 1)) begin
                    st_next.cmd = S_HDR;
                    st_next.run_rate = ucr_field(nvm_reg,
                                                 ucr_pkg::IDX_RATE); // [RULE6]
                end else begin
                    st_next.boot_idx = st_reg.boot_idx + 3'h1;
                end
            end
            S_HDR: if (u_rx_valid && u_rx_data == ucr_pkg::HDR_BYTE) begin
                st_next.cmd = S_SIZE;
            end
            S_SIZE: if (u_rx_valid) begin
                st_next.cmd = (u_rx_data == ucr_pkg::SIZE_BYTE) ? S_ADR : S_HDR;
            end
            S_ADR: if (u_rx_valid) begin
                // Escape marks a read; anything else is the write address
                if (u_rx_data == ucr_pkg::ESC_BYTE) begin
                    st_next.cmd = S_RADR; // [RULE1]
                end else begin
                    st_next.addr = u_rx_data;
                    st_next.cmd = S_VAL; // [RULE2]
                end
            end
            S_RADR: if (u_rx_valid) begin
                st_next.addr = u_rx_data;
                st_next.resp_cnt = 2'h0;
                st_next.cmd = S_RESP;
                d = ucr_decode(u_rx_data);
                st_next.resp_val = d[3] ? ucr_field(nvm_reg, d[2:0])
                                        : ucr_field(st_reg.vol, d[2:0]);
            end
            S_VAL: if (u_rx_valid) begin
                // Writes are stored as given, including the wait limit
                if (a_idx != ucr_pkg::IDX_NONE) begin
                    if (a_nvm) begin
                        nvm_next[a_idx*8 +: 8] = u_rx_data; // [RULE6]
                    end else if (a_idx == ucr_pkg::IDX_RATE) begin
                        st_next.vol[a_idx*8 +: 8] = u_rx_data;
                        st_next.pend_rate = u_rx_data;
                        st_next.pend_sw = 1'b1; // [RULE7]
                    end else begin
                        st_next.vol[a_idx*8 +: 8] = u_rx_data; // [RULE17]
                    end
                end
                st_next.resp_cnt = 2'h2;
                st_next.cmd = S_RESP;
            end
            S_RESP: begin
                // Write answers with a lone ack, or nak for an unknown address; read adds address and value
                u_tx_valid = 1'b1;
                unique case (st_reg.resp_cnt)
                    2'h1: u_tx_data = st_reg.addr;
                    2'h2: u_tx_data = (a_idx == ucr_pkg::IDX_NONE &&
                                       !st_reg.pend_sw) ?
                                      ucr_pkg::NAK_BYTE : ucr_pkg::ACK_BYTE;
                    2'h3: u_tx_data = st_reg.resp_val;
                    default: u_tx_data = ucr_pkg::ACK_BYTE;
                endcase
                if (u_tx_ready) begin
                    if (st_reg.resp_cnt == 2'h0) begin
                        st_next.resp_cnt = 2'h1;
                    end else if (st_reg.resp_cnt == 2'h1) begin
                        st_next.resp_cnt = 2'h3;
                    end else begin
                        st_next.cmd = S_HDR;
                    end
                end
            end
            default: st_next.cmd = S_HDR;
        endcase
        // Rate switch only after the acknowledge byte has left the line
        if (st_reg.pend_sw && st_reg.cmd == S_HDR && u_tx_ready
            && !u_tx_valid) begin
            st_next.pend_sw = 1'b0;
            st_next.run_rate = st_reg.pend_rate; // [RULE7]
        end
        // Retry engine
        slow = st_reg.run_rate <= ucr_pkg::RATE_SLOW_MAX;
        unique case (st_reg.tx)
            T_IDLE: if (pkt_send && st_reg.cmd != S_BOOT) begin
                st_next.tries = 8'h0;
                st_next.attempt = 1'b1;
                st_next.tx = T_SEND;
            end
            T_SEND: if (pkt_sent) begin
                st_next.to_cnt = slow ? 24'(ucr_pkg::ACK_TO_SLOW_CYC)
                                      : 24'(ucr_pkg::ACK_TO_FAST_CYC); // [RULE11]
                st_next.tx = T_WAIT;
            end
            T_WAIT: begin
                if (radio_ack) begin
                    st_next.tx = T_IDLE;
                end else if (st_reg.to_cnt > 24'h1) begin
                    st_next.to_cnt = st_reg.to_cnt - 24'h1;
                end else if (st_reg.tries <
                             ucr_field(st_reg.vol, ucr_pkg::IDX_RTRY)) begin
                    // Each attempt costs send time plus timeout
                    st_next.tries = st_reg.tries + 8'h1; // [RULE9] [RULE12]
                    st_next.attempt = 1'b1;
                    st_next.tx = T_SEND;
                end else begin
                    st_next.exc = 1'b1; // [RULE10]
                    st_next.tx = T_IDLE;
                end
            end
            default: st_next.tx = T_IDLE;
        endcase
        // Header errors always drop; payload check only when enabled
        if (rx_pkt && rx_hdr_ok) begin
            st_next.deliver = rx_encrypted || rx_crc_ok ||
                (ucr_field(st_reg.vol, ucr_pkg::IDX_CRC) == ucr_pkg::CRC_OFF); // [RULE13] [RULE15]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.cmd <= S_BOOT;
            st_reg.boot_idx <= 3'h0;
            st_reg.vol <= '0;
            st_reg.addr <= 8'h00;
            st_reg.resp_cnt <= 2'h0;
            st_reg.resp_val <= 8'h00;
            st_reg.run_rate <= ucr_pkg::RATE_DEF; // [RULE8]
            st_reg.pend_rate <= ucr_pkg::RATE_DEF;
            st_reg.pend_sw <= 1'b0;
            st_reg.tx <= T_IDLE;
            st_reg.tries <= 8'h00;
            st_reg.to_cnt <= 24'h0;
            st_reg.exc <= 1'b0;
            st_reg.attempt <= 1'b0;
            st_reg.deliver <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk) nvm_reg <= nvm_next;

    ucr_uart u_uart (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bit_cycles(ucr_pkg::ucr_bit_cycles(st_reg.run_rate)), // [RULE4]
        .tx_valid(u_tx_valid),
        .tx_data(u_tx_data),
        .tx_ready(u_tx_ready),
        .tx_pin(link.dev_to_host),
        .rx_pin(link.host_to_dev),
        .rx_valid(u_rx_valid),
        .rx_data(u_rx_data)
    );

    assign pkt_attempt = st_reg.attempt;
    assign no_radio_ack_exception = st_reg.exc;
    assign tx_active = st_reg.tx != T_IDLE;
    assign rx_deliver = st_reg.deliver;
    assign air_rate_bps = (st_reg.run_rate <= ucr_pkg::RATE_SLOW_MAX) ?
        18'(ucr_pkg::AIR_SLOW_BPS) : 18'(ucr_pkg::AIR_FAST_BPS); // [RULE5]
    assign serial_rate_select = st_reg.run_rate;
    assign ready = st_reg.cmd != S_BOOT;
endmodule

/* File: design/ucr_host.sv */
/*
 Host end: frames read and write commands from a user request port and
 returns the answer value. Follows a volatile rate write itself.
 Assumes the device answers every command.
*/
`timescale 1ns/1ps
module ucr_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    ucr_link_if.host link,
    // Request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_value,
    output logic req_ready,
    // Answer
    output logic rsp_valid,
    output logic [7:0] rsp_ack,
    output logic [7:0] rsp_value
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00, H_SEND = 2'b01, H_WAIT = 2'b10
    } ucr_host_ph_t;

    typedef struct packed {
        ucr_host_ph_t ph;
        logic wr;
        logic [7:0] addr;
        logic [7:0] val;
        logic [2:0] idx;
        logic [1:0] got;
        logic [7:0] ack;
        logic [7:0] rval;
        logic [7:0] rate;
        logic rsp;
    } ucr_host_st_t;

    ucr_host_st_t st_reg, st_next;
    logic u_tx_ready, u_rx_valid;
    logic [7:0] u_tx_data, u_rx_data;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.rsp = 1'b0;
        unique case (st_reg.idx)
            3'h0: u_tx_data = ucr_pkg::HDR_BYTE;
            3'h1: u_tx_data = ucr_pkg::SIZE_BYTE;
            3'h2: u_tx_data = st_reg.wr ? st_reg.addr : ucr_pkg::ESC_BYTE;
            default: u_tx_data = st_reg.wr ? st_reg.val : st_reg.addr;
        endcase
        unique case (st_reg.ph)
            H_IDLE: if (req_valid) begin
                st_next = '{ph: H_SEND, wr: req_write, addr: req_addr,
                            val: req_value, rate: st_reg.rate,
                            default: '0};
            end
            H_SEND: if (u_tx_ready) begin
                if (st_reg.idx == 3'h3) begin
                    st_next.ph = H_WAIT;
                end else begin
                    st_next.idx = st_reg.idx + 3'h1;
                end
            end
            H_WAIT: if (u_rx_valid) begin
                // Write: one ack byte; read: ack, address, value
                st_next.got = st_reg.got + 2'h1;
                if (st_reg.got == 2'h0) begin
                    st_next.ack = u_rx_data;
                end
                if (st_reg.wr || st_reg.got == 2'h2) begin
                    st_next.rval = u_rx_data;
                    st_next.rsp = 1'b1;
                    st_next.ph = H_IDLE;
                    if (st_reg.wr && st_reg.addr == ucr_pkg::A_RATE_V) begin
                        st_next.rate = st_reg.val; // [RULE7]
                    end
                end
            end
            default: st_next.ph = H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{ph: H_IDLE, rate: ucr_pkg::RATE_DEF, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    ucr_uart u_uart (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bit_cycles(ucr_pkg::ucr_bit_cycles(st_reg.rate)),
        .tx_valid(st_reg.ph == H_SEND),
        .tx_data(u_tx_data),
        .tx_ready(u_tx_ready),
        .tx_pin(link.host_to_dev),
        .rx_pin(link.dev_to_host),
        .rx_valid(u_rx_valid),
        .rx_data(u_rx_data)
    );

    assign req_ready = st_reg.ph == H_IDLE;
    assign rsp_valid = st_reg.rsp;
    assign rsp_ack = st_reg.ack;
    assign rsp_value = st_reg.rval;
endmodule

/* File: tb/ucr_checker.sv */
/*
 Wire checks on both link lines.
 Assumes rates between 9600 and 115200 on a 125 MHz sys_clk.
*/
`timescale 1ns/1ps
module ucr_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    input wire logic host_to_dev,
    input wire logic dev_to_host
);
    // One bit at the fastest rate, nine bits at the slowest
    localparam int MIN_BIT = 1084;
    localparam int MAX_LOW = 117182;
    logic [16:0] h_low_reg, d_low_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_low_reg <= 17'h00000;
            d_low_reg <= 17'h00000;
        end else begin
            h_low_reg <= host_to_dev ? 17'h00000 : h_low_reg + 17'h00001;
            d_low_reg <= dev_to_host ? 17'h00000 : d_low_reg + 17'h00001;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    host_low_min_a: assert property (
        $rose(host_to_dev) && h_low_reg != 0 |-> h_low_reg >= MIN_BIT)
        else $error("host line low too short");
    host_low_max_a: assert property (h_low_reg <= MAX_LOW)
        else $error("host line low too long");
    dev_low_min_a: assert property (
        $rose(dev_to_host) && d_low_reg != 0 |-> d_low_reg >= MIN_BIT)
        else $error("device line low too short");
    dev_low_max_a: assert property (d_low_reg <= MAX_LOW)
        else $error("device line low too long");
    // Answers never overlap a command in flight
    dev_quiet_a: assert property (!host_to_dev |-> dev_to_host)
        else $error("device talks during command");
    host_quiet_a: assert property (!dev_to_host |-> host_to_dev)
        else $error("host talks during answer");
    cover property ($fell(host_to_dev));
    cover property ($fell(dev_to_host));
    cover property ($rose(dev_to_host) && d_low_reg >= MIN_BIT);
endmodule

/* File: tb/test_uart_config_register_commands.sv */
/*
 Bench driving the host request port and the device radio ports.
 Assumes the link interface joins the two ends directly.
*/
`timescale 1ns/1ps
module test_uart_config_register_commands;
    logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [7:0] req_addr = 8'h00, req_value = 8'h00, seen, tries, fails;
    logic pkt_send = 1'b0, pkt_sent = 1'b0, radio_ack = 1'b0, rx_pkt = 1'b0;
    logic rx_encrypted = 1'b0, rx_crc_ok = 1'b1, rx_hdr_ok = 1'b1;
    logic req_ready, rsp_valid, pkt_attempt, no_radio_ack_exception;
    logic tx_active, rx_deliver, ready;
    logic [7:0] rsp_ack, rsp_value, serial_rate_select;
    logic [17:0] air_rate_bps;
    int err_count = 0, num_checks = 0, cycles = 0;
    ucr_link_if ucr_link_if_i ();
    ucr_device ucr_device_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(ucr_link_if_i), .pkt_send(pkt_send), .pkt_sent(pkt_sent),
        .radio_ack(radio_ack), .pkt_attempt(pkt_attempt),
        .no_radio_ack_exception(no_radio_ack_exception),
        .tx_active(tx_active), .rx_pkt(rx_pkt), .rx_encrypted(rx_encrypted),
        .rx_crc_ok(rx_crc_ok), .rx_hdr_ok(rx_hdr_ok), .rx_deliver(rx_deliver),
        .air_rate_bps(air_rate_bps), .serial_rate_select(serial_rate_select),
        .ready(ready));
    ucr_host ucr_host_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(ucr_link_if_i), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_value(req_value), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_value(rsp_value));
    ucr_checker ucr_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .host_to_dev(ucr_link_if_i.host_to_dev),
        .dev_to_host(ucr_link_if_i.dev_to_host));
    ////////////////////////////////////////////////////////////////////
    always #4 sys_clk = ~sys_clk;
    // Two slow commands dominate the run time
    always @(posedge sys_clk) begin
        seen <= seen + {7'h00, rx_deliver === 1'b1};
        tries <= tries + {7'h00, pkt_attempt === 1'b1};
        fails <= fails + {7'h00, no_radio_ack_exception === 1'b1};
        cycles++;
        if (cycles == 3000000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [17:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic wr, input logic [7:0] a, v, ack, val);
        @(negedge sys_clk);
        {req_valid, req_write, req_addr, req_value} = {1'b1, wr, a, v};
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        do @(negedge sys_clk); while (rsp_valid !== 1'b1);
        check("rsp_ack", rsp_ack, ack);
        check("rsp_value", rsp_value, val);
    endtask
    task automatic rx(input logic crc, hdr, input logic [7:0] exp);
        @(negedge sys_clk);
        {seen, rx_pkt, rx_crc_ok, rx_hdr_ok} = {8'h00, 1'b1, crc, hdr};
        @(negedge sys_clk);
        rx_pkt = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("rx_deliver", seen, exp);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge sys_clk);
        {rst_n, tries, fails} = {1'b1, 16'h0000};
        while (ready !== 1'b1) @(negedge sys_clk);
        check("rate", serial_rate_select, 8'h01);
        check("air", air_rate_bps, 18'h04B00);
        rx(1'b0, 1'b1, 8'h00);
        cmd(1'b1, ucr_pkg::A_RATE_N, 8'h03, 8'h06, 8'h06);
        check("rate", serial_rate_select, 8'h01);
        cmd(1'b1, ucr_pkg::A_RATE_V, 8'h05, 8'h06, 8'h06);
        repeat (20000) @(negedge sys_clk);
        check("rate", serial_rate_select, 8'h05);
        check("air", air_rate_bps, 18'h25800);
        cmd(1'b0, ucr_pkg::A_RATE_V, 8'h00, 8'h06, 8'h05);
        cmd(1'b0, ucr_pkg::A_RATE_N, 8'h00, 8'h06, 8'h03);
        cmd(1'b1, ucr_pkg::A_WAIT_V, 8'h5A, 8'h06, 8'h06);
        cmd(1'b0, ucr_pkg::A_WAIT_V, 8'h00, 8'h06, 8'h5A);
        cmd(1'b0, ucr_pkg::A_ADDR_V, 8'h00, 8'h06, 8'h00);
        cmd(1'b1, ucr_pkg::A_CRC_V, 8'h00, 8'h06, 8'h06);
        rx(1'b0, 1'b1, 8'h01);
        rx(1'b1, 1'b0, 8'h00);
        cmd(1'b1, 8'h99, 8'h00, 8'h15, 8'h15);
        @(negedge sys_clk) pkt_send = 1'b1;
        @(negedge sys_clk) {pkt_send, pkt_sent} = 2'b01;
        @(negedge sys_clk) {pkt_sent, radio_ack} = 2'b01;
        @(negedge sys_clk) radio_ack = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("attempts", tries, 8'h01);
        check("exception", fails, 8'h00);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        while (ready !== 1'b1) @(negedge sys_clk);
        check("rate", serial_rate_select, 8'h03);
        check("air", air_rate_bps, 18'h25800);
        rx(1'b0, 1'b1, 8'h00);
        report_and_stop();
    end
endmodule
